// [common/timer0_pkg.sv]
/*
  timer0_pkg: register map, field positions, reset values and carrier
  types for the 8-bit timer compare and flag block.
  assumes the processor core presents one register access per cycle.
*/
// Operation
// [RULE1] compare value a checked against counter always
// [RULE2] compare value b checked against counter always
// [RULE3] match b sets flag bit 2
// [RULE4] match a sets flag bit 1
// [RULE5] counter overflow sets flag bit 0
// [RULE6] taken vector clears its own flag
// [RULE7] writing one clears flag, zero keeps
// [RULE8] gie, enable b, flag b request irq b
// [RULE9] gie, enable a, flag a request irq a
// [RULE10] gie, overflow enable, flag request overflow irq
// [RULE11] waveform mode selects the overflow point
// [RULE12] io address equals data address minus 0x20
// [RULE13] addresses from 0x60 only by load/store
// [RULE14] mask register 0x6E, bits 2..0, reset zero
// [RULE15] counter write blocks match on next tick
// [RULE16] force strobe moves output, no flag; the code ignores the strobe in pwm modes
// [RULE17] hardware set beats software clear
// [RULE18] flag bits 7..3 read zero, ignore writes
package timer0_pkg;

  // data-space offsets
  localparam logic [7:0] FLAG_OFS    = 8'h35;
  localparam logic [7:0] COUNT_OFS   = 8'h46;
  localparam logic [7:0] CMP_A_OFS   = 8'h47;
  localparam logic [7:0] CMP_B_OFS   = 8'h48;
  localparam logic [7:0] MASK_OFS    = 8'h6E;
  localparam logic [7:0] IO_SHIFT    = 8'h20;
  localparam logic [7:0] IO_LIMIT    = 8'h40;
  localparam logic [7:0] EXT_START   = 8'h60;

  // field positions in flag and mask registers
  localparam int OVF_BIT   = 0;
  localparam int MATCH_A_BIT = 1;
  localparam int MATCH_B_BIT = 2;
  localparam int FLAG_W    = 3;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX   = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // waveform mode encodings
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_PC_MAX   = 3'h1;
  localparam logic [2:0] MODE_CTC      = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_CMP   = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;

  typedef enum {SEL_NONE, SEL_FLAG, SEL_COUNT, SEL_CMP_A, SEL_CMP_B,
                SEL_MASK} reg_sel_t;

  // one access from the core
  typedef struct packed {
    logic [7:0] addr;     // data-space or io address
    logic       io_space; // 1: io instruction address
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  // per-flag event lines
  typedef struct packed {
    logic match_b;
    logic match_a;
    logic ovf;
  } flag_evt_t;

endpackage

// [logic/flag_cell.sv]
/*
  flag_cell: one sticky interrupt flag.
  assumes set, clear and vector strobes are on clk.
*/
`timescale 1ns/10ps
module flag_cell (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic set_evt,
  input  wire logic sw_clr,
  input  wire logic vec_clr,
  output logic      flag_reg
);
  import timer0_pkg::*;

  // set wins over both clears
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_reg <= 1'b0;
    end else if (set_evt) begin
      flag_reg <= 1'b1;                  // [RULE17]
    end else if (sw_clr || vec_clr) begin
      flag_reg <= 1'b0;                  // [RULE6] [RULE7]
    end
  end

  flag_set_a : assert property (@(posedge clk) disable iff (!rst_b)
    set_evt |=> flag_reg)                // [RULE17]
    else $error("flag not set after event");
  flag_clr_a : assert property (@(posedge clk) disable iff (!rst_b)
    (sw_clr || vec_clr) && !set_evt |=> !flag_reg) // [RULE7]
    else $error("flag not cleared");

endmodule // flag_cell

// [logic/timer0_core.sv]
/*
  timer0_core: 8-bit counter, two compare units, flag and mask
  registers, interrupt requests and waveform outputs.
  assumes the core, tick, vector acknowledge and force strobes all
  come from logic on clk.
*/
`timescale 1ns/10ps
module timer0_core (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire timer0_pkg::reg_req_t req,
  input  wire logic                 timer_tick,
  input  wire logic [2:0]           waveform_mode_select,
  input  wire logic                 global_irq_enable,
  input  wire timer0_pkg::flag_evt_t vec_taken,
  input  wire logic                 force_compare_strobe_a,
  input  wire logic                 force_compare_strobe_b,
  output logic [7:0]                rd_data_reg,
  output timer0_pkg::flag_evt_t     irq_reg,
  output logic                      wave_out_a,
  output logic                      wave_out_b
);
  import timer0_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // address decode

  // io addresses sit 0x20 below data addresses; io reaches < 0x60
  function automatic reg_sel_t decode(input reg_req_t r);
    logic [7:0] eff;
    eff = r.io_space ? 8'(r.addr + IO_SHIFT) : r.addr; // [RULE12]
    if (r.io_space && r.addr >= IO_LIMIT) begin
      return SEL_NONE;                   // [RULE13]
    end
    unique case (eff)
      FLAG_OFS:  return SEL_FLAG;
      COUNT_OFS: return SEL_COUNT;
      CMP_A_OFS: return SEL_CMP_A;
      CMP_B_OFS: return SEL_CMP_B;
      MASK_OFS:  return SEL_MASK;
      default:   return SEL_NONE;
    endcase
  endfunction

  reg_sel_t   sel;
  logic [7:0] counter_value_reg;
  logic [7:0] compare_value_a_reg;
  logic [7:0] compare_value_b_reg;
  logic [2:0] timer_irq_mask_register_reg;
  logic [2:0] flags;
  logic       count_down_reg;
  logic       block_reg;
  logic [7:0] top;
  logic       pwm_mode;
  logic       phase_mode;
  logic       at_top;
  logic       ovf_evt;
  logic       hit_a;
  logic       hit_b;
  logic       cnt_wr;

  assign sel    = decode(req);
  assign cnt_wr = req.wr && sel == SEL_COUNT;

  ////////////////////////////////////////////////////////////////////
  // mode decode: top value and overflow point

  assign pwm_mode   = waveform_mode_select[0];
  assign phase_mode = waveform_mode_select == MODE_PC_MAX ||
                      waveform_mode_select == MODE_PC_CMP;
  assign top = (waveform_mode_select == MODE_CTC ||
                waveform_mode_select == MODE_PC_CMP ||
                waveform_mode_select == MODE_FAST_CMP)
               ? compare_value_a_reg : CNT_MAX;
  assign at_top = counter_value_reg == top;

  // overflow at max, at top, or at bottom when counting down
  always_comb begin
    ovf_evt = 1'b0;
    if (timer_tick && !cnt_wr) begin
      if (phase_mode) begin
        ovf_evt = count_down_reg &&
                  counter_value_reg == 8'(CNT_BOTTOM + 8'h01); // [RULE11]
      end else if (waveform_mode_select == MODE_FAST_CMP) begin
        ovf_evt = at_top;                // [RULE11]
      end else begin
        ovf_evt = counter_value_reg == CNT_MAX; // [RULE11]
      end
    end
  end

  // continuous compare, gated by tick and by the write block
  assign hit_a = timer_tick && !block_reg && !cnt_wr &&
                 counter_value_reg == compare_value_a_reg; // [RULE1]
  assign hit_b = timer_tick && !block_reg && !cnt_wr &&
                 counter_value_reg == compare_value_b_reg; // [RULE2]

  ////////////////////////////////////////////////////////////////////
  // counter

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      counter_value_reg <= REG_RESET;
      count_down_reg    <= 1'b0;
    end else if (cnt_wr) begin
      counter_value_reg <= req.wdata;
    end else if (timer_tick) begin
      if (phase_mode) begin
        if (!count_down_reg && at_top) begin
          count_down_reg    <= 1'b1;
          counter_value_reg <= 8'(counter_value_reg - 8'h01);
        end else if (count_down_reg &&
                     counter_value_reg == CNT_BOTTOM) begin
          count_down_reg    <= 1'b0;
          counter_value_reg <= 8'(counter_value_reg + 8'h01);
        end else if (count_down_reg) begin
          counter_value_reg <= 8'(counter_value_reg - 8'h01);
        end else begin
          counter_value_reg <= 8'(counter_value_reg + 8'h01);
        end
      end else begin
        count_down_reg    <= 1'b0;
        counter_value_reg <= at_top ? CNT_BOTTOM
                             : 8'(counter_value_reg + 8'h01);
      end
    end
  end

  // a counter write blocks the match at the following tick
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1;                 // [RULE15]
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // compare and mask registers

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      compare_value_a_reg <= REG_RESET;
    end else if (req.wr && sel == SEL_CMP_A) begin
      compare_value_a_reg <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      compare_value_b_reg <= REG_RESET;
    end else if (req.wr && sel == SEL_CMP_B) begin
      compare_value_b_reg <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_irq_mask_register_reg <= FLAG_W'(REG_RESET); // [RULE14]
    end else if (req.wr && sel == SEL_MASK) begin
      timer_irq_mask_register_reg <= req.wdata[FLAG_W-1:0]; // [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flags: one cell per source

  logic [2:0] set_vec;
  logic [2:0] vec_vec;
  assign set_vec[OVF_BIT]     = ovf_evt;  // [RULE5]
  assign set_vec[MATCH_A_BIT] = hit_a;    // [RULE4]
  assign set_vec[MATCH_B_BIT] = hit_b;    // [RULE3]
  assign vec_vec = vec_taken;

  for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
    flag_cell u_flag (
      .clk      (clk),
      .rst_b    (rst_b),
      .set_evt  (set_vec[i]),
      .sw_clr   (req.wr && sel == SEL_FLAG && req.wdata[i]), // [RULE7]
      .vec_clr  (vec_vec[i]),            // [RULE6]
      .flag_reg (flags[i])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt requests

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_reg <= '0;
    end else begin
      irq_reg.match_b <= global_irq_enable &&
        timer_irq_mask_register_reg[MATCH_B_BIT] &&
        flags[MATCH_B_BIT];              // [RULE8]
      irq_reg.match_a <= global_irq_enable &&
        timer_irq_mask_register_reg[MATCH_A_BIT] &&
        flags[MATCH_A_BIT];              // [RULE9]
      irq_reg.ovf <= global_irq_enable &&
        timer_irq_mask_register_reg[OVF_BIT] && flags[OVF_BIT]; // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // waveform outputs: toggle on match or force in non-pwm modes

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else if (pwm_mode) begin
      wave_out_a <= counter_value_reg < compare_value_a_reg;
      wave_out_b <= counter_value_reg < compare_value_b_reg;
    end else begin
      if (hit_a || force_compare_strobe_a) begin
        wave_out_a <= !wave_out_a;       // [RULE1] [RULE16]
      end
      if (hit_b || force_compare_strobe_b) begin
        wave_out_b <= !wave_out_b;       // [RULE2] [RULE16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_reg <= REG_RESET;
    end else if (req.rd) begin
      unique case (sel)
        SEL_FLAG:  rd_data_reg <= {5'h00, flags}; // [RULE18]
        SEL_COUNT: rd_data_reg <= counter_value_reg;
        SEL_CMP_A: rd_data_reg <= compare_value_a_reg;
        SEL_CMP_B: rd_data_reg <= compare_value_b_reg;
        SEL_MASK:  rd_data_reg <= {5'h00, timer_irq_mask_register_reg};
        SEL_NONE:  rd_data_reg <= REG_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  match_a_flag_a : assert property (hit_a |=> flags[MATCH_A_BIT]) // [RULE4]
    else $error("match a did not set flag");
  match_b_flag_a : assert property (hit_b |=> flags[MATCH_B_BIT]) // [RULE3]
    else $error("match b did not set flag");
  ovf_flag_a : assert property (ovf_evt |=> flags[OVF_BIT]) // [RULE5]
    else $error("overflow did not set flag");
  write_block_a : assert property (cnt_wr ##1 (!cnt_wr && timer_tick)
    |-> !hit_a && !hit_b)                // [RULE15]
    else $error("match after counter write");
  irq_b_gate_a : assert property (irq_reg.match_b == $past(
    global_irq_enable && timer_irq_mask_register_reg[MATCH_B_BIT]
    && flags[MATCH_B_BIT]))              // [RULE8]
    else $error("irq b mismatch");
  irq_a_gate_a : assert property (irq_reg.match_a |->
    $past(flags[MATCH_A_BIT]) && $past(global_irq_enable)) // [RULE9]
    else $error("irq a without flag");
  irq_ovf_gate_a : assert property (irq_reg.ovf |->
    $past(timer_irq_mask_register_reg[OVF_BIT])) // [RULE10]
    else $error("overflow irq without enable");
  force_noflag_a : assert property (force_compare_strobe_a && !hit_a
    && !flags[MATCH_A_BIT] && !pwm_mode |=> !flags[MATCH_A_BIT]
    && wave_out_a != $past(wave_out_a)) // [RULE16]
    else $error("force strobe set flag or missed toggle");
  flag_read_a : assert property (req.rd && sel == SEL_FLAG |=>
    rd_data_reg[7:3] == 5'h00)           // [RULE18]
    else $error("flag reserved bits nonzero");
  normal_ovf_a : assert property (timer_tick && !cnt_wr &&
    waveform_mode_select == MODE_NORMAL && counter_value_reg == CNT_MAX
    |=> counter_value_reg == CNT_BOTTOM && flags[OVF_BIT]) // [RULE11]
    else $error("normal mode wrap wrong");

  cover_match_a_c : cover property (hit_a ##1 irq_reg.match_a);
  cover_ovf_c     : cover property (ovf_evt ##[1:3] irq_reg.ovf);
  cover_block_c   : cover property (cnt_wr ##1 timer_tick);
  cover_w1c_c     : cover property (req.wr && sel == SEL_FLAG && hit_a);

endmodule // timer0_core

// [verif/core_bus_model.sv]
/*
  core_bus_model: processor core side of the timer register bus.
  assumes timer0_pkg is compiled first and one access per call.
*/
`timescale 1ns/10ps
module core_bus_model (
  input  wire logic            clk,
  output timer0_pkg::reg_req_t req,
  input  wire logic [7:0]      rd_data_reg
);
  import timer0_pkg::*;

  // bus idle from time zero
  initial req = '0;

  //////////////////////////////////////////////////////////////////////
  // io calls drop the address by the io offset; an io call on an
  // extended register is a deliberate misuse that must be ignored
  function automatic logic [7:0] map(input logic [7:0] a,
                                     input logic io);
    return io ? a - IO_SHIFT : a;
  endfunction

  // one write, held up to its sampling edge
  task automatic wr(input logic [7:0] a, input logic io,
                    input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: map(a, io), io_space: io, wr: 1'b1, rd: 1'b0,
             wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  // one read, data taken at the edge after the one that samples it
  task automatic rd(input logic [7:0] a, input logic io,
                    output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: map(a, io), io_space: io, wr: 1'b0, rd: 1'b1,
             wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    d = rd_data_reg;
  endtask
endmodule // core_bus_model

// [verif/tb_timer0_core.sv]
/*
  tb_timer0_core: random register and tick traffic against a small
  reference model of counter, flags, requests and wave outputs.
  assumes random waveform modes and the core_bus_model partner.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_timer0_core;
  import timer0_pkg::*;
  logic       clk = 0, rst_b = 0, tick = 0, gie = 0, fa = 0, fb = 0;
  flag_evt_t  vec = '0, irq;
  reg_req_t   req;
  logic [7:0] rd_data, v, m, cnt, ca, cb;
  logic       wa, wb, blk, ea, eb, dn;
  logic [2:0] fl, en;
  logic [2:0] wm = 3'h0;
  logic [31:0] lf = 32'h1A98;
  int         bad_count = 0, total_checks = 0;

  always #2 clk = ~clk;

  timer0_core u_timer0_core (
    .clk(clk), .rst_b(rst_b), .req(req), .timer_tick(tick),
    .waveform_mode_select(wm), .global_irq_enable(gie),
    .vec_taken(vec), .force_compare_strobe_a(fa),
    .force_compare_strobe_b(fb), .rd_data_reg(rd_data),
    .irq_reg(irq), .wave_out_a(wa), .wave_out_b(wb));

  core_bus_model u_core_bus_model (
    .clk(clk), .req(req), .rd_data_reg(rd_data));

  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // flags, requests and wave outputs against the model
  task automatic chk_all();
    @(posedge clk);
    u_core_bus_model.rd(FLAG_OFS, lf[0], v);
    // pwm modes: output is the counter below compare level
    if (wm[0]) begin
      ea = cnt < ca;
      eb = cnt < cb;
    end
    `CHK("flags", {5'h00, fl}, v)
    `CHK("irq", fl & en & {3{gie}}, irq)
    `CHK("wave_a", ea, wa)
    `CHK("wave_b", eb, wb)
  endtask

  // model step for one strobe cycle of tick, vector and force
  task automatic mdl(input logic t, input logic [2:0] vc,
                     input logic [1:0] f);
    logic       ma, mb, ov, ph;
    logic [7:0] tp;
    ph = wm == MODE_PC_MAX || wm == MODE_PC_CMP;
    tp = (wm == MODE_CTC || wm == MODE_PC_CMP || wm == MODE_FAST_CMP)
         ? ca : CNT_MAX;
    ma = t && !blk && cnt == ca;
    mb = t && !blk && cnt == cb;
    ov = t && (ph ? dn && cnt == 8'h01
               : cnt == (wm == MODE_FAST_CMP ? tp : CNT_MAX));
    fl = (fl & ~vc) | {mb, ma, ov};
    if (!wm[0]) begin
      ea ^= ma | f[0];
      eb ^= mb | f[1];
    end
    if (t) begin
      blk = 0;
      if (!ph) begin
        dn = 0;
      end else if (dn ? cnt == CNT_BOTTOM : cnt == tp) begin
        dn = !dn;
      end
      if (!ph && cnt == tp) begin
        cnt = CNT_BOTTOM;
      end else begin
        cnt = dn ? cnt - 8'h01 : cnt + 8'h01;
      end
    end
  endtask

  // one strobe cycle of tick, vector and force, model updated alike
  task automatic pulse(input logic t, input logic [2:0] vc,
                       input logic [1:0] f);
    @(posedge clk);
    tick <= t; vec <= vc; fa <= f[0]; fb <= f[1];
    @(posedge clk);
    tick <= 0; vec <= '0; fa <= 0; fb <= 0;
    mdl(t, vc, f);
  endtask

  //////////////////////////////////////////////////////////////////////
  // watchdog for a hung run
  initial begin
    #100000;
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    fl = 0; en = 0; ca = 0; cb = 0; cnt = 0; blk = 0; ea = 0; eb = 0;
    dn = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    chk_all();
    u_core_bus_model.rd(MASK_OFS, 0, v);
    `CHK("mask_rst", 8'h00, v)
    u_core_bus_model.rd(CMP_A_OFS, 0, v);
    `CHK("cmp_a_rst", 8'h00, v)
    u_core_bus_model.rd(8'h50, 0, v);
    `CHK("unmapped", 8'h00, v)
    for (int i = 0; i < 20; i++) begin
      lf = nx(lf);
      @(posedge clk);
      gie <= lf[3];
      wm <= lf[30:28];
      cnt = {5'h1E, lf[2:0]};
      ca = cnt + lf[11:8];
      cb = cnt + lf[15:12];
      en = lf[18:16];
      u_core_bus_model.wr(CMP_A_OFS, lf[19], ca);
      u_core_bus_model.wr(CMP_B_OFS, lf[20], cb);
      u_core_bus_model.wr(MASK_OFS, 0, {5'h00, en});
      u_core_bus_model.wr(MASK_OFS, 1, 8'h07);
      u_core_bus_model.rd(CMP_A_OFS, !lf[19], v);
      `CHK("cmp_a", ca, v)
      u_core_bus_model.rd(CMP_B_OFS, !lf[20], v);
      `CHK("cmp_b", cb, v)
      u_core_bus_model.rd(MASK_OFS, 0, v);
      `CHK("mask", {5'h00, en}, v)
      blk = 1;
      // counter write with a tick on the very next cycle: match blocked
      fork
        u_core_bus_model.wr(COUNT_OFS, lf[21], cnt);
        begin
          repeat (2) @(posedge clk);
          tick <= 1;
          @(posedge clk);
          tick <= 0;
        end
      join
      mdl(1, 3'h0, 2'h0);
      for (int k = 0; k < 12; k++) begin
        pulse(1, 3'h0, 2'h0);
        chk_all();
      end
      pulse(0, lf[24:22], lf[26:25]);
      chk_all();
      m = lf[31:24];
      u_core_bus_model.wr(FLAG_OFS, lf[27], m);
      fl &= ~m[2:0];
      chk_all();
    end
    test_done();
  end
endmodule // tb_timer0_core
